// ===== verilog/flash_ctl_map.svh
// constants for the parallel flash host controller: register offsets, command codes, timing counts
// assumes pclk at 250 MHz and a byte-wide asynchronous flash on the far side
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define REG_CMD 12'h000
`define REG_ADDR 12'h004
`define REG_WDATA 12'h008
`define REG_STATUS 12'h00C
`define REG_RDATA 12'h010
// ****************************************
// command register fields
// ****************************************
`define CMD_OP_LSB 0
`define CMD_OP_MSB 3
`define CMD_START_BIT 4
// ****************************************
// flash codes and unlock addresses
// ****************************************
`define UNLOCK_A1 11'h555
`define UNLOCK_A2 11'h2AA
`define DATA_UNLOCK1 8'hAA
`define DATA_UNLOCK2 8'h55
`define DATA_PROGRAM 8'hA0
`define DATA_ERASE_SETUP 8'h80
`define DATA_CHIP_ERASE 8'h10
`define DATA_SECTOR_ERASE 8'h30
`define DATA_RESUME 8'h30
`define DATA_SUSPEND 8'hB0
`define DATA_RESET 8'hF0
`define DATA_ID 8'h90
`define DATA_PROTECT_UNLOCK 8'h20
`define PROTECT_VERIFY_LOW 18'h0_0002
// ****************************************
// timing: pulse widths, read access, sector load window
// ****************************************
`define CLK_MHZ 250
`define PHASE_NS 60
`define PHASE_CYC ((`PHASE_NS * `CLK_MHZ + 999) / 1000)
`define LOAD_WINDOW_US 30
`define LOAD_WINDOW_CYC (`LOAD_WINDOW_US * `CLK_MHZ)
`endif

// ===== verilog/flash_ctl_pkg.sv
// types for the parallel flash host controller
// assumes flash_ctl_map.svh supplies the numbers
package flash_ctl_pkg;
  // operations software can order
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_PROGRAM = 4'h1,
    OP_CHIP_ERASE = 4'h2,
    OP_SECTOR_ERASE = 4'h3,
    OP_SECTOR_ADD = 4'h4,
    OP_SUSPEND = 4'h5,
    OP_RESUME = 4'h6,
    OP_RESET = 4'h7,
    OP_ID = 4'h8,
    OP_PROTECT_UNLOCK = 4'h9,
    OP_STATUS_READ = 4'hA
  } op_t;
  // flash pin bundle driven by the host
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [17:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
  } flash_pins_t;
  // one bus cycle handed to the pin sequencer
  typedef struct packed {
    logic wr;
    logic [17:0] addr;
    logic [7:0] data;
  } flash_cycle_t;
endpackage

// ===== verilog/flash_cycle_seq.sv
// one asynchronous flash bus cycle (write or read) generated from pclk
// assumes the flash data pins are synchronised by the caller before use
`timescale 1ns/1ns
`include "flash_ctl_map.svh"
module flash_cycle_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire flash_ctl_pkg::flash_cycle_t cyc,
  input wire logic [7:0] dq_sync,
  output flash_ctl_pkg::flash_pins_t pins,
  output logic [7:0] rdata,
  output logic done
);
  import flash_ctl_pkg::*;
  localparam int PW = `PHASE_CYC;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_SET = 2'b01, S_ACT = 2'b11, S_REC = 2'b10} seq_t;
  seq_t state_reg;
  logic [7:0] cnt_reg;
  logic wr_reg;
  // ****************************************
  // strobe phase timing
  // ****************************************
  // select and address lead the strobe by one cycle so the address has setup time at the falling edge;
  // select stays low through recovery so the strobe rise is never raced by the select rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 18'h0_0000, dq_out: 8'h00, dq_oe: 1'b0};
      rdata <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            wr_reg <= cyc.wr;
            pins.addr <= cyc.addr;
            pins.dq_out <= cyc.data;
            pins.dq_oe <= cyc.wr; // R25
            pins.ce_n <= 1'b0;
            state_reg <= S_SET;
          end
        end
        S_SET: begin
          pins.we_n <= ~wr_reg; // R7 R26
          pins.oe_n <= wr_reg; // R25
          cnt_reg <= 8'(PW);
          state_reg <= S_ACT;
        end
        S_ACT: begin
          if (cnt_reg == 8'h00) begin
            if (!wr_reg) begin
              rdata <= dq_sync;
            end
            pins.we_n <= 1'b1; // R7
            pins.oe_n <= 1'b1;
            cnt_reg <= 8'(PW);
            state_reg <= S_REC;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_REC: begin
          if (cnt_reg == 8'h00) begin
            pins.dq_oe <= 1'b0;
            pins.ce_n <= 1'b1;
            done <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== verilog/flash_host_ctl.sv
// host controller for a byte-wide command-driven NOR flash, ordered over APB
// assumes the flash pins settle within the read phase and the bench joins dq from the host's dq_oe alone
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ns
`include "flash_ctl_map.svh"
// Contract
// R1: program is two unlocks, A0 code, then address and data write.
// R2: unlock and command addresses carry 555 or 2AA on low eleven bits.
// R3: device ignores upper address bits on plain command cycles.
// R4: device times and verifies program itself; host only polls.
// R5: chip erase pre-programs, erases and verifies inside the device.
// R6: sector erase pre-programs only selected sectors inside the device.
// R7: device latches address at strobe fall, data at strobe rise.
// R8: device ignores commands during byte program.
// R9: during sector erase only suspend is honoured.
// R10: after suspend the device stays in read mode.
// R11: after completion the full command set is accepted again.
// R12: wrong or misordered writes return the device to read mode.
// R13: suspend and resume are valid only during sector erase.
// R14: after failure one F0 write aborts; host then gives a command.
// R15: after reset reads return array data until another command.
// R16: after ID sequence address 0 gives maker, address 1 device code.
// R17: busy status shows a polling bit and a toggling bit.
// R18: protect verify read with address bit 1 high gives 01 or 00.
// R19: sector address is the top five address bits.
// R20: host sends six-cycle protect unlock before protect work.
// R21: chip erase is six writes ending in code 10.
// R22: further sector loads must begin within 30 us of last strobe rise.
// R23: erase done when poll bit is one and toggle bit stops. The host checks only that bit 6 stops toggling.
// R24: erase time-out shows as data bit 5 high.
// R25: outputs driven only with select and output enable low.
// R26: select and strobe low with output enable high is a write.
module flash_host_ctl #(
  parameter int LOAD_WINDOW = `LOAD_WINDOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] dq_in,
  output flash_ctl_pkg::flash_pins_t flash
);
  import flash_ctl_pkg::*;
  typedef enum logic [2:0] {
    C_IDLE = 3'b000, C_ISSUE = 3'b001, C_WAIT = 3'b011, C_POLL = 3'b010, C_POLLW = 3'b110
  } ctl_t;
  ctl_t state_reg;
  op_t op_reg;
  logic [17:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic [2:0] step_reg;
  logic [2:0] steps;
  logic busy_reg, fail_reg, window_reg;
  logic [7:0] last_poll_reg;
  logic first_poll_reg, q5_seen_reg;
  logic [15:0] win_cnt_reg;
  logic [7:0] dq_meta_reg, dq_sync_reg;
  logic seq_start_reg;
  flash_cycle_t cyc_reg;
  logic [7:0] seq_rdata;
  logic seq_done;
  logic bus_wr, bus_rd;

  // ****************************************
  // pin input synchroniser
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_meta_reg <= 8'h00;
      dq_sync_reg <= 8'h00;
    end else begin
      dq_meta_reg <= dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  flash_cycle_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(seq_start_reg),
    .cyc(cyc_reg),
    .dq_sync(dq_sync_reg),
    .pins(flash),
    .rdata(seq_rdata),
    .done(seq_done)
  );

  // ****************************************
  // apb slave: zero wait states, errors on unmapped address only
  // ****************************************
  assign bus_wr = psel && penable && pwrite;
  assign bus_rd = psel && !penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {`REG_CMD, `REG_ADDR, `REG_WDATA, `REG_STATUS, `REG_RDATA});
      if (bus_rd) begin
        case (paddr)
          `REG_CMD: prdata <= {28'h000_0000, op_reg};
          `REG_ADDR: prdata <= {14'h0000, addr_reg};
          `REG_WDATA: prdata <= {24'h00_0000, wdata_reg};
          `REG_STATUS: prdata <= {28'h000_0000, window_reg, fail_reg, 1'b0, busy_reg};
          `REG_RDATA: prdata <= {24'h00_0000, rdata_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // address and data operands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= 18'h0_0000;
      wdata_reg <= 8'h00;
    end else if (bus_wr && pready) begin
      if (paddr == `REG_ADDR) addr_reg <= pwdata[17:0];
      if (paddr == `REG_WDATA) wdata_reg <= pwdata[7:0];
    end
  end

  // index of the last flash cycle each operation needs; that cycle is the read for ID, verify, status
  always_comb begin
    case (op_reg)
      OP_PROGRAM: steps = 3'd3; // R1
      OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_PROTECT_UNLOCK: steps = 3'd5; // R21 R20
      OP_ID: steps = 3'd3; // R16
      OP_READ, OP_STATUS_READ: steps = 3'd0;
      default: steps = 3'd0; // suspend, resume, reset, sector add
    endcase
  end

  // cycle contents for the current step
  function automatic flash_cycle_t make_cycle(op_t op, logic [2:0] step, logic [17:0] a, logic [7:0] d);
    flash_cycle_t c;
    c = '{wr: 1'b1, addr: {7'h00, `UNLOCK_A1}, data: `DATA_UNLOCK1}; // R2 R3
    case (step)
      3'd1, 3'd4: c = '{wr: 1'b1, addr: {7'h00, `UNLOCK_A2}, data: `DATA_UNLOCK2}; // R2
      3'd2: c.data = (op == OP_PROGRAM) ? `DATA_PROGRAM : (op == OP_ID) ? `DATA_ID : `DATA_ERASE_SETUP;
      3'd0, 3'd3: c.data = `DATA_UNLOCK1; // R2
      default: c.data = `DATA_UNLOCK1;
    endcase
    if (step == 3'd3 && op == OP_PROGRAM) c = '{wr: 1'b1, addr: a, data: d}; // R1
    if (step == 3'd3 && op == OP_ID) c = '{wr: 1'b0, addr: a, data: 8'h00}; // R16 R18
    if (step == 3'd5) begin
      case (op)
        OP_CHIP_ERASE: c.data = `DATA_CHIP_ERASE; // R21
        OP_PROTECT_UNLOCK: c.data = `DATA_PROTECT_UNLOCK; // R20
        default: c = '{wr: 1'b1, addr: {a[17:13], 13'h0000}, data: `DATA_SECTOR_ERASE}; // R19
      endcase
    end
    if (step == 3'd0) begin
      case (op)
        OP_SUSPEND: c = '{wr: 1'b1, addr: a, data: `DATA_SUSPEND}; // R9 R10 R13
        OP_RESUME: c = '{wr: 1'b1, addr: a, data: `DATA_RESUME}; // R13
        OP_RESET: c = '{wr: 1'b1, addr: a, data: `DATA_RESET}; // R14
        OP_SECTOR_ADD: c = '{wr: 1'b1, addr: {a[17:13], 13'h0000}, data: `DATA_SECTOR_ERASE}; // R22
        OP_READ, OP_STATUS_READ: c = '{wr: 1'b0, addr: a, data: 8'h00}; // R15
        default: c = c;
      endcase
    end
    return c;
  endfunction

  // ****************************************
  // command sequencer and completion polling
  // ****************************************
  // chip erase and program are polled until the toggle bit stands still or bit 5 shows on two polls in a row; host never times the device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= C_IDLE;
      op_reg <= OP_READ;
      step_reg <= 3'd0;
      busy_reg <= 1'b0;
      fail_reg <= 1'b0;
      rdata_reg <= 8'h00;
      last_poll_reg <= 8'h00;
      first_poll_reg <= 1'b0;
      q5_seen_reg <= 1'b0;
      seq_start_reg <= 1'b0;
      cyc_reg <= '{wr: 1'b0, addr: 18'h0_0000, data: 8'h00};
    end else begin
      seq_start_reg <= 1'b0;
      case (state_reg)
        C_IDLE: begin
          if (bus_wr && pready && paddr == `REG_CMD && pwdata[`CMD_START_BIT]) begin // R8 R9
            op_reg <= op_t'(pwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
            step_reg <= 3'd0;
            busy_reg <= 1'b1;
            if (op_t'(pwdata[`CMD_OP_MSB:`CMD_OP_LSB]) == OP_RESET) fail_reg <= 1'b0; // R14
            state_reg <= C_ISSUE;
          end
        end
        C_ISSUE: begin
          cyc_reg <= make_cycle(op_reg, step_reg, addr_reg, wdata_reg);
          seq_start_reg <= 1'b1;
          state_reg <= C_WAIT;
        end
        C_WAIT: begin
          if (seq_done) begin
            rdata_reg <= seq_rdata; // R15 R16 R18
            if (step_reg != steps) begin
              step_reg <= step_reg + 3'd1; // R12
              state_reg <= C_ISSUE;
            end else if (op_reg inside {OP_PROGRAM, OP_CHIP_ERASE}) begin
              // the first poll only seeds the toggle history; stale read data must not end the wait
              first_poll_reg <= 1'b1;
              q5_seen_reg <= 1'b0;
              state_reg <= C_POLL; // R4 R5
            end else begin
              busy_reg <= 1'b0; // R6 R22: sector erase runs on while host may add sectors
              state_reg <= C_IDLE;
            end
          end
        end
        C_POLL: begin
          cyc_reg <= '{wr: 1'b0, addr: addr_reg, data: 8'h00};
          seq_start_reg <= 1'b1;
          state_reg <= C_POLLW;
        end
        C_POLLW: begin
          if (seq_done) begin
            last_poll_reg <= seq_rdata;
            rdata_reg <= seq_rdata;
            if (first_poll_reg) begin
              first_poll_reg <= 1'b0;
              state_reg <= C_POLL;
            end else if (seq_rdata[6] == last_poll_reg[6]) begin // R17 R23
              busy_reg <= 1'b0; // R11
              state_reg <= C_IDLE;
            end else if (seq_rdata[5] && q5_seen_reg) begin // R24
              // bit 5 alone may be array data on the read that ends the job, so one more look is taken
              fail_reg <= 1'b1;
              busy_reg <= 1'b0;
              state_reg <= C_IDLE;
            end else begin
              q5_seen_reg <= seq_rdata[5];
              state_reg <= C_POLL;
            end
          end
        end
        default: state_reg <= C_IDLE;
      endcase
    end
  end

  // ****************************************
  // sector load window after each sector erase write
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_reg <= 16'h0000;
      window_reg <= 1'b0;
    end else if (seq_done && state_reg == C_WAIT && cyc_reg.data == `DATA_SECTOR_ERASE
                 && op_reg inside {OP_SECTOR_ERASE, OP_SECTOR_ADD}) begin
      win_cnt_reg <= 16'(LOAD_WINDOW); // R22
      window_reg <= 1'b1;
    end else if (win_cnt_reg != 16'h0000) begin
      win_cnt_reg <= win_cnt_reg - 16'h0001;
    end else begin
      window_reg <= 1'b0;
    end
  end
endmodule

// ===== bench/flash_host_ctl_sva.sv
// port checks for the flash host controller
// assumes binding to the top module, one clock domain
`timescale 1ns/1ns
module flash_host_ctl_sva #(
  parameter int LOAD_WINDOW = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] dq_in,
  input wire flash_ctl_pkg::flash_pins_t flash
);
  import flash_ctl_pkg::*;
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  // a short strobe would break the device's edge latching
  sequence strobe_low_s;
    !flash.we_n [*8];
  endsequence
  apb_answer_a: assert property (setup_s |=> pready && psel && penable)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  write_cycle_a: assert property (!flash.we_n |-> !flash.ce_n && flash.oe_n && flash.dq_oe)
    else $error("bad write cycle pins");
  read_cycle_a: assert property (!flash.oe_n |-> !flash.ce_n && flash.we_n && !flash.dq_oe)
    else $error("bad read cycle pins");
  strobe_width_a: assert property ($fell(flash.we_n) |-> strobe_low_s)
    else $error("write strobe too short");
  addr_hold_a: assert property (!flash.ce_n && $past(!flash.ce_n) |-> $stable(flash.addr))
    else $error("address moved in cycle");
  data_hold_a: assert property ($rose(flash.we_n) |-> flash.dq_oe && $stable(flash.dq_out))
    else $error("data moved at strobe rise");
endmodule

// ===== bench/flash_dev_model.sv
// behavioural flash device at the far end of the controller
// assumes the bench resolves the data wire from the host's dq_oe alone
`timescale 1ns/1ns
module flash_dev_model #(
  parameter logic [7:0] MAKER = 8'h5A, // arbitrary value
  parameter logic [7:0] PART = 8'hA5, // arbitrary value
  parameter logic [4:0] LOCKED = 5'h1F,
  parameter int TICKS = 20
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [17:0] addr,
  input wire logic [7:0] din,
  input wire logic fail_en,
  output logic [7:0] dq
);
  logic [7:0] mem [logic [17:0]];
  logic [17:0] wa;
  logic [7:0] pd;
  logic [4:0] sec;
  logic [2:0] step;
  logic [1:0] mode; // 0 array, 1 code reads, 2 program, 3 erase
  logic chip, susp, tog;
  int left;
  // ****************************************
  // command decoder
  // ****************************************
  initial begin
    step = 0; mode = 0; susp = 0; tog = 0; left = 0; dq = 8'h00;
  end
  always @(negedge we_n) if (!ce_n) wa = addr;
  always @(posedge we_n) if (!ce_n) begin
    if (mode == 2 || (mode == 3 && !fail_en)) begin
      if (mode == 3 && din == 8'hB0) susp = 1;
      if (mode == 3 && din == 8'h30) susp = 0;
    end else if (din == 8'hF0) begin
      mode = 0; step = 0; susp = 0;
    end else case (step)
      0, 3: step = (wa[10:0] == 11'h555 && din == 8'hAA) ? step + 1 : 0;
      1, 4: step = (wa[10:0] == 11'h2AA && din == 8'h55) ? step + 1 : 0;
      2: begin
        step = 0;
        if (wa[10:0] == 11'h555 && din == 8'hA0) step = 6;
        if (wa[10:0] == 11'h555 && din == 8'h80) step = 3;
        if (wa[10:0] == 11'h555 && din == 8'h90) mode = 1;
      end
      5: begin
        step = 0;
        left = TICKS;
        if (din == 8'h30) begin chip = 0; sec = wa[17:13]; mode = 3; end
        if (wa[10:0] == 11'h555 && din == 8'h10) begin chip = 1; mode = 3; end
        if (wa[10:0] == 11'h555 && din == 8'h20) mode = 1;
      end
      default: begin step = 0; mem[wa] = din; pd = din; mode = 2; left = TICKS; end
    endcase
  end
  // self-timed work; a timed-out erase never finishes
  always #100 if (mode[1] && !susp && left > 0) begin
    left = left - 1;
    if (left == 0 && !fail_en) begin
      if (mode == 3) foreach (mem[a]) if (chip || a[17:13] == sec) mem[a] = 8'hFF;
      mode = 0;
    end
  end
  always @(posedge oe_n) if (!ce_n && mode[1]) tog = ~tog;
  // undriven pins show the inverse so stale data cannot match
  always @(ce_n, oe_n, addr, mode, tog, susp) begin
    if (ce_n || oe_n) dq = ~dq;
    else if (mode[1] && !susp) dq = {mode == 2 && !pd[7], tog, mode == 3 && fail_en, 5'h00};
    else if (mode == 1) dq = addr[1] ? {7'h00, addr[17:13] == LOCKED} : (addr[0] ? PART : MAKER);
    else dq = mem.exists(addr) ? mem[addr] : 8'hFF;
  end
endmodule

// ===== bench/tb_flash_host_ctl.sv
// self-checking bench: APB master driving the controller and a flash model
// assumes one access cycle per APB transfer
`timescale 1ns/1ns
`include "flash_ctl_map.svh"
module tb_flash_host_ctl;
  import flash_ctl_pkg::*;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] PART = 8'hA5; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fail_en, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [7:0] dq_in, dev_dq;
  flash_pins_t flash;
  int failures, tests_run, cycles;
  // ****************************************
  // clock, pins, instances
  // ****************************************
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  assign dq_in = flash.dq_oe ? flash.dq_out : dev_dq;
  flash_host_ctl #(.LOAD_WINDOW(50)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dq_in(dq_in), .flash(flash));
  flash_dev_model #(.MAKER(MAKER), .PART(PART)) dev_u (.ce_n(flash.ce_n), .oe_n(flash.oe_n),
    .we_n(flash.we_n), .addr(flash.addr), .din(flash.dq_out), .fail_en(fail_en), .dq(dev_dq));
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      finish_test();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // orders one operation and waits until busy clears
  task automatic op(input logic [3:0] o, input logic [17:0] a, input logic [7:0] d);
    apb(1, `REG_ADDR, {14'h0000, a});
    apb(1, `REG_WDATA, {24'h00_0000, d});
    apb(1, `REG_CMD, {27'h000_0000, 1'b1, o});
    repeat (400) begin
      apb(0, `REG_STATUS, '0);
      if (rv[0] === 1'b0) break;
    end
    check({31'h0, rv[0]}, 32'h0000_0000);
  endtask
  task automatic rd(input logic [17:0] a);
    op(OP_READ, a, 8'h00);
    apb(0, `REG_RDATA, '0);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_basic();
    apb(0, `REG_STATUS, '0);
    check(rv, 32'h0000_0000);
    apb(0, 12'h0FC, '0);
    check({31'h0, er}, 32'h0000_0001);
    op(OP_PROGRAM, 18'h3_F0A5, 8'h3C);
    rd(18'h3_F0A5);
    check(rv, 32'h0000_003C);
    op(OP_ID, 18'h0_0000, 8'h00);
    apb(0, `REG_RDATA, '0);
    check(rv, {24'h00_0000, MAKER});
    op(OP_ID, 18'h0_0001, 8'h00);
    apb(0, `REG_RDATA, '0);
    check(rv, {24'h00_0000, PART});
    op(OP_RESET, 18'h0_0000, 8'h00);
    rd(18'h3_F0A5);
    check(rv, 32'h0000_003C);
    $display("program and id test done");
  endtask
  task automatic t_chip();
    fail_en <= 1;
    op(OP_CHIP_ERASE, 18'h0_0000, 8'h00);
    check({31'h0, rv[2]}, 32'h0000_0001);
    op(OP_RESET, 18'h0_0000, 8'h00);
    fail_en <= 0;
    rd(18'h3_F0A5);
    check(rv, 32'h0000_003C);
    op(OP_CHIP_ERASE, 18'h0_0000, 8'h00);
    check({31'h0, rv[2]}, 32'h0000_0000);
    rd(18'h3_F0A5);
    check(rv, 32'h0000_00FF);
    $display("chip erase test done");
  endtask
  task automatic t_sector();
    op(OP_PROGRAM, 18'h0_2001, 8'h11);
    op(OP_PROGRAM, 18'h0_4001, 8'h22);
    op(OP_SECTOR_ERASE, 18'h0_2000, 8'h00);
    apb(0, `REG_STATUS, '0);
    check({31'h0, rv[3]}, 32'h0000_0001);
    op(OP_SECTOR_ADD, 18'h0_6000, 8'h00);
    check({31'h0, rv[3]}, 32'h0000_0001);
    op(OP_SUSPEND, 18'h0_0000, 8'h00);
    rd(18'h0_4001);
    check(rv, 32'h0000_0022);
    op(OP_RESUME, 18'h0_0000, 8'h00);
    repeat (60) begin
      rd(18'h0_2001);
      if (rv[7:0] === 8'hFF) break;
    end
    check(rv, 32'h0000_00FF);
    rd(18'h0_4001);
    check(rv, 32'h0000_0022);
    op(OP_PROTECT_UNLOCK, 18'h0_0000, 8'h00);
    rd(18'h3_E002);
    check(rv, 32'h0000_0001);
    rd(18'h0_0002);
    check(rv, 32'h0000_0000);
    $display("sector and protect test done");
  endtask
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    fail_en = 0; failures = 0; tests_run = 0; cycles = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_basic();
    t_chip();
    t_sector();
    finish_test();
  end
endmodule
bind flash_host_ctl flash_host_ctl_sva #(.LOAD_WINDOW(LOAD_WINDOW)) chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dq_in(dq_in), .flash(flash));
